// ===== src/pll_cfg.svh
// Purpose: constants of the PLL core clock control block
// Assumes: clk_i stands in for the PLL output clock
// Notes: offsets are register indices; byte address is four times the index
`ifndef PLL_CFG_SVH
`define PLL_CFG_SVH
// Behaviour
// - PLL runs at 512 times the 32.768 kHz crystal, about 16.78 MHz
// - Core runs at full PLL clock or a software chosen binary submultiple
// - After power-on the core clock is the PLL clock divided by 8
// - ADC clocks come from the PLL clock; modulator runs at crystal rate
// - Modulator and core clocks stay synchronous at every divided core rate, not under external clock select
// - Control bit 7 set stops the oscillator in power-down; clear keeps it
// - Bit 6 is read-only lock status, set at power-on when tracking
// - No tracking at power-on clears lock; PLL free-runs within 20 percent
// - Crystal lost after lock rails the PLL and stops the core clock
// - Bits 2..0 pick divide by 2 to the n; default code is 011
// - Fast interrupt bit 3 runs interrupt service at the fastest clock
// - External clock select takes the core clock from a port pin
`define CLK_HZ 10000000
`define XTAL_HZ 32768
`define PLL_MULT 512
`define XTAL_CYC (`CLK_HZ / `XTAL_HZ)
`define LOCK_WIN_CYC (4 * `XTAL_CYC)
`define LOSS_CYC (2 * `XTAL_CYC)
`define IDX_PLL_CTL 10'h0D7
`define IDX_CHIP_CFG 10'h0AF
`define IDX_IRQ_STS 10'h0E0
`define IDX_IRQ_CLR 10'h0E1
`define IDX_IRQ_EN 10'h0E2
`define PLL_CTL_RST 8'h53
`define B_OSC_HALT 7
`define B_LOCK 6
`define B_EXTERNAL_CLOCK_SELECT 4
`define B_FAST_IRQ_CLOCKING 3
`define EV_RAIL 0
`define EV_SWITCH 1
`endif

// ===== src/pll_pkg.sv
// Purpose: types of the PLL core clock control block
// Assumes: nothing beyond the constants header
// Notes: counter widths cover the window counts
package pll_pkg;
    typedef enum logic [1:0] {PH_CHECK, PH_LOCKED, PH_FREE, PH_RAILED} phase_t;
    typedef struct packed {
        logic [2:0] xs;
        logic [2:0] es;
        logic [8:0] cnt;
        logic [2:0] sel;
        logic [7:0] ctl;
        logic extsel;
        phase_t phase;
        logic [10:0] win;
        logic [1:0] edges;
        logic lock;
        logic [10:0] loss;
        logic [1:0] sts;
        logic [1:0] en;
        logic ack;
        logic [7:0] dat;
        logic core_tick;
        logic mod_tick;
        logic halt;
        logic osc;
        logic irq;
    } state_t;
endpackage

// ===== src/pll_clock_control.sv
// Purpose: core clock divider, modulator tick, lock watch and control register
// Assumes: clk_i is the PLL output; xtal_i and ext_clk_i are async pins
// Notes: core and modulator clocks leave as one-cycle enables
//
// Chosen here: register access over Wishbone.
`include "pll_cfg.svh"
`timescale 1ns/1ps
module pll_clock_control #(
    parameter int LOCK_EDGES = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins
    input wire logic xtal_i,
    input wire logic ext_clk_i,
    // Core status
    input wire logic irq_active_i,
    input wire logic power_down_i,
    // Clock enables and status
    output logic core_tick_o,
    output logic mod_tick_o,
    output logic lock_o,
    output logic core_halt_o,
    output logic osc_halt_o,
    output logic irq_o
);
    import pll_pkg::*;

    localparam logic [10:0] LOCK_WIN = 11'(`LOCK_WIN_CYC);
    localparam logic [10:0] LOSS_LIM = 11'(`LOSS_CYC);
    localparam logic [8:0] MOD_LAST = 9'(`PLL_MULT - 1);
    localparam logic [1:0] LOCK_MIN = 2'(LOCK_EDGES);

    // Whole state at reset: divide by eight, lock check pending
    localparam state_t RST_STATE = '{
        xs: 3'h0,
        es: 3'h0,
        cnt: 9'h000,
        sel: 3'h3,
        ctl: `PLL_CTL_RST,
        extsel: 1'b0,
        phase: PH_CHECK,
        win: 11'h000,
        edges: 2'h0,
        lock: 1'b0,
        loss: 11'h000,
        sts: 2'h0,
        en: 2'h0,
        ack: 1'b0,
        dat: 8'h00,
        core_tick: 1'b0,
        mod_tick: 1'b0,
        halt: 1'b0,
        osc: 1'b0,
        irq: 1'b0
    };

    if (LOCK_EDGES < 1 || LOCK_EDGES > 3) begin : g_chk_edges
        $error("LOCK_EDGES must be 1 to 3");
    end
    if (`PLL_MULT != 512) begin : g_chk_mult
        $error("Counter is sized for a multiplier of 512");
    end
    if (`LOCK_WIN_CYC > 2047 || `LOSS_CYC > 2047) begin : g_chk_win
        $error("Window counts exceed the 11-bit counters");
    end
    if (`LOSS_CYC < 2 * `XTAL_CYC) begin : g_chk_loss
        $error("Loss limit shorter than two crystal periods");
    end

    state_t s_q;
    state_t s_d;
    logic xedge;
    logic eedge;
    logic tick_int;
    logic hit;
    logic wr;
    logic [2:0] want;
    logic [8:0] mask;
    logic [1:0] ev;
    logic [1:0] clr;

    always_comb begin
        s_d = s_q;
        ev = 2'h0;
        clr = 2'h0;
        s_d.xs = {s_q.xs[1:0], xtal_i};
        s_d.es = {s_q.es[1:0], ext_clk_i};
        xedge = s_q.xs[1] & ~s_q.xs[2];
        eedge = s_q.es[1] & ~s_q.es[2];

        // Free-running base count at PLL rate
        s_d.cnt = s_q.cnt + 9'h001;
        want = (s_q.ctl[`B_FAST_IRQ_CLOCKING] && irq_active_i) ? 3'h0 : s_q.ctl[2:0];
        mask = 9'((9'h001 << s_q.sel) - 9'h001);
        tick_int = (s_q.cnt & mask) == mask;
        // Divider swaps only on a divided edge
        if (tick_int && want != s_q.sel) begin
            s_d.sel = want;
            ev[`EV_SWITCH] = 1'b1;
        end
        if (s_q.phase == PH_RAILED) begin
            s_d.core_tick = 1'b0;
        end else if (s_q.extsel) begin
            s_d.core_tick = eedge;
        end else begin
            s_d.core_tick = tick_int;
        end
        s_d.mod_tick = (s_q.cnt == MOD_LAST) && (s_q.phase != PH_RAILED);

        // Lock check at power-on, then loss watch
        unique case (s_q.phase)
            PH_CHECK: begin
                s_d.win = s_q.win + 11'h001;
                if (xedge && s_q.edges != 2'h3) begin
                    s_d.edges = s_q.edges + 2'h1;
                end
                if (s_q.win == LOCK_WIN - 11'h001) begin
                    if (s_q.edges >= LOCK_MIN) begin
                        s_d.phase = PH_LOCKED;
                        s_d.lock = 1'b1;
                    end else begin
                        s_d.phase = PH_FREE;
                        s_d.lock = 1'b0;
                    end
                end
            end
            PH_LOCKED: begin
                if (xedge || s_q.osc) begin
                    s_d.loss = 11'h000;
                end else begin
                    s_d.loss = s_q.loss + 11'h001;
                end
                if (s_q.loss == LOSS_LIM - 11'h001 && !s_q.osc) begin
                    s_d.phase = PH_RAILED;
                    s_d.lock = 1'b0;
                    ev[`EV_RAIL] = 1'b1;
                end
            end
            PH_FREE: begin
                s_d.lock = 1'b0;
            end
            PH_RAILED: begin
                s_d.lock = 1'b0;
            end
        endcase
        s_d.halt = (s_d.phase == PH_RAILED);
        s_d.osc = s_q.ctl[`B_OSC_HALT] & power_down_i;

        // Wishbone slave: one wait state, unmapped reads zero
        hit = wb_cyc_i & wb_stb_i & ~s_q.ack;
        wr = hit & wb_we_i & wb_sel_i[0];
        s_d.ack = hit;
        s_d.dat = 8'h00;
        if (hit && !wb_we_i) begin
            unique case (wb_adr_i)
                `IDX_PLL_CTL: s_d.dat = {s_q.ctl[7], s_q.lock, s_q.ctl[5:0]};
                `IDX_CHIP_CFG: s_d.dat = {3'h0, s_q.extsel, 4'h0};
                `IDX_IRQ_STS: s_d.dat = {6'h00, s_q.sts};
                `IDX_IRQ_EN: s_d.dat = {6'h00, s_q.en};
                default: s_d.dat = 8'h00;
            endcase
        end
        if (wr) begin
            unique case (wb_adr_i)
                // Lock bit ignores writes
                `IDX_PLL_CTL: s_d.ctl = {wb_dat_i[7], s_q.ctl[6], wb_dat_i[5:0]};
                `IDX_CHIP_CFG: s_d.extsel = wb_dat_i[`B_EXTERNAL_CLOCK_SELECT];
                `IDX_IRQ_CLR: clr = wb_dat_i[1:0];
                `IDX_IRQ_EN: s_d.en = wb_dat_i[1:0];
                default: ;
            endcase
        end
        // New events win over a clear in the same cycle
        s_d.sts = (s_q.sts & ~clr) | ev;
        s_d.irq = |(s_d.sts & s_d.en);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = {24'h000000, s_q.dat};
    assign wb_ack_o = s_q.ack;
    assign core_tick_o = s_q.core_tick;
    assign mod_tick_o = s_q.mod_tick;
    assign lock_o = s_q.lock;
    assign core_halt_o = s_q.halt;
    assign osc_halt_o = s_q.osc;
    assign irq_o = s_q.irq;

    // Gap between modulator ticks, for checking only
    logic [9:0] mgap_q;
    logic mseen_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || core_halt_o) begin
            mgap_q <= 10'h000;
            mseen_q <= 1'b0;
        end else if (mod_tick_o) begin
            mgap_q <= 10'h000;
            mseen_q <= 1'b1;
        end else begin
            mgap_q <= mgap_q + 10'h001;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_mod_period: assert property (mod_tick_o && mseen_q |-> mgap_q == 10'd511)
        else $error("modulator tick not at crystal rate");
    a_mod_sync: assert property (mod_tick_o && !$past(s_q.extsel) |-> core_tick_o)
        else $error("modulator tick off a core edge");
    a_lock_ro: assert property (wr && wb_adr_i == `IDX_PLL_CTL && s_d.phase == s_q.phase
                                |-> s_d.lock == s_q.lock)
        else $error("write changed lock status");
    a_rail_halts: assert property (core_halt_o |=> !core_tick_o && !mod_tick_o)
        else $error("core clock runs after rail");
    a_osc_halt: assert property (power_down_i && s_q.ctl[7] |=> osc_halt_o)
        else $error("oscillator not halted in power-down");
    a_osc_run: assert property (!s_q.ctl[7] |=> !osc_halt_o)
        else $error("oscillator halted with bit clear");
    a_div_eight: assert property (core_tick_o && s_q.sel == 3'h3 && !s_q.extsel && !core_halt_o
                                  && s_q.ctl[3:0] == 4'h3 |-> ##1 (!core_tick_o)[*7])
        else $error("divide by eight period wrong");
    a_switch_clean: assert property ($changed(s_q.sel) && !$past(s_q.extsel) && !core_halt_o
                                     |-> core_tick_o)
        else $error("divider changed off a divided edge");
    a_free_run: assert property (s_q.phase == PH_FREE |-> !lock_o)
        else $error("lock set while free-running");
    a_irq_level: assert property (irq_o == |(s_q.sts & s_q.en))
        else $error("interrupt level does not match status");

    // Register bus
    a_ack_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data not zero outside ack");
    a_dat_upper: assert property (wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_ctl_write: assert property (wr && wb_adr_i == `IDX_PLL_CTL |=> s_q.ctl[5:0] == $past(wb_dat_i[5:0])
                                  && s_q.ctl[7] == $past(wb_dat_i[7]))
        else $error("control write not stored");
    a_en_write: assert property (wr && wb_adr_i == `IDX_IRQ_EN
                                 |=> s_q.en == $past(wb_dat_i[1:0]))
        else $error("enable write not stored");

    // Divider and ticks
    a_fast_sel: assert property (s_q.ctl[`B_FAST_IRQ_CLOCKING] && irq_active_i && tick_int |=> s_q.sel == 3'h0)
        else $error("fast interrupt clock not selected");
    a_div_follow: assert property (!s_q.ctl[`B_FAST_IRQ_CLOCKING] && tick_int
                                   |=> s_q.sel == $past(s_q.ctl[2:0]))
        else $error("divider code not applied");
    a_sel_hold: assert property (!tick_int |=> $stable(s_q.sel))
        else $error("divider changed between divided edges");
    a_ext_tick: assert property ($past(s_q.extsel) && $past(s_q.phase) != PH_RAILED
                                 |-> core_tick_o == $past(eedge))
        else $error("external clock edge not passed on");
    a_mod_single: assert property (mod_tick_o |=> !mod_tick_o)
        else $error("modulator tick longer than one cycle");
    a_mod_count: assert property (mod_tick_o |-> $past(s_q.cnt) == MOD_LAST)
        else $error("modulator tick off the count end");

    // Lock and loss
    a_lock_check: assert property (s_q.phase == PH_CHECK |-> !lock_o)
        else $error("lock set before the check ends");
    a_lock_set: assert property (s_q.phase == PH_LOCKED |-> lock_o)
        else $error("lock clear while tracking");
    a_rail_lock: assert property (s_q.phase == PH_RAILED |-> !lock_o && core_halt_o)
        else $error("railed without halt");
    a_halt_phase: assert property (core_halt_o == (s_q.phase == PH_RAILED))
        else $error("halt does not follow rail");
    a_rail_event: assert property (s_q.phase == PH_RAILED && $past(s_q.phase) == PH_LOCKED
                                   |-> s_q.sts[`EV_RAIL])
        else $error("rail did not set its status");
    a_rail_entry: assert property (s_q.phase == PH_RAILED
                                   |-> $past(s_q.phase) inside {PH_LOCKED, PH_RAILED})
        else $error("rail entered without lock");
    a_pause_loss: assert property (s_q.osc && s_q.phase == PH_LOCKED |=> s_q.phase == PH_LOCKED)
        else $error("rail while oscillator halted");
    a_window_bound: assert property (s_q.phase == PH_CHECK |-> s_q.win < LOCK_WIN)
        else $error("lock window overran");
    a_oscillator_sleep_halt: assert property (osc_halt_o |-> $past(power_down_i))
        else $error("oscillator halted outside power-down");

    // Sticky status
    a_sticky_rail: assert property ($fell(s_q.sts[0]) |-> $past(clr[0]))
        else $error("rail status lost without clear");
    a_sticky_switch: assert property ($fell(s_q.sts[1]) |-> $past(clr[1]))
        else $error("switch status lost without clear");
    a_set_wins: assert property (ev[0] |=> s_q.sts[0])
        else $error("rail event lost against clear");
endmodule // pll_clock_control

// ===== verification/xtal_model.sv
// Purpose: behavioural 32.768 kHz watch crystal
// Assumes: clk_i is the 10 MHz system clock
// Notes: a halted or missing crystal rests low
`timescale 1ns/1ps
module xtal_model #(
    parameter int HALF_CYC = 152
) (
    // Clock
    input wire logic clk_i,
    // Control
    input wire logic fitted_i,
    input wire logic halt_i,
    // Pin
    output logic xtal_o
);
    logic [7:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (!fitted_i || halt_i) begin
            xtal_o <= 1'b0;
            cnt_q <= 8'h00;
        end else if (cnt_q == 8'(HALF_CYC - 1)) begin
            xtal_o <= !xtal_o;
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // xtal_model

// ===== verification/test_pll_clock_control.sv
// Purpose: self-checking bench of the PLL core clock control block
// Assumes: 10 MHz clock stands in for the PLL output
// Notes: registers are reached over classic Wishbone
`timescale 1ns/1ps
`include "pll_cfg.svh"
module test_pll_clock_control;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, irq_act = 0, pdn = 0, ext_clk = 0, ext_run = 0, fitted = 1;
    logic [9:0] adr = 0;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 0, rdat;
    logic ack, xtal, tick, mtick, lock, halt, osc_halt, irq;
    int n_errors = 0, total_checks = 0, cycles = 0, nt, nm, nbad;
    always #50 clk_i = ~clk_i;
    pll_clock_control u_pll_clock_control (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .xtal_i(xtal), .ext_clk_i(ext_clk), .irq_active_i(irq_act), .power_down_i(pdn), .core_tick_o(tick),
        .mod_tick_o(mtick), .lock_o(lock), .core_halt_o(halt), .osc_halt_o(osc_halt), .irq_o(irq));
    xtal_model u_xtal_model (.clk_i(clk_i), .fitted_i(fitted), .halt_i(osc_halt), .xtal_o(xtal));
    always begin
        repeat (10) @(posedge clk_i);
        ext_clk <= ext_run & ~ext_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [7:0] exp = 0);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        if (!w) check("read data", rdat, {24'h000000, exp});
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic count(input int n);
        nt = 0;
        nm = 0;
        nbad = 0;
        repeat (n) begin
            @(negedge clk_i);
            nt += (tick === 1'b1);
            nm += (mtick === 1'b1);
            nbad += (mtick === 1'b1 && tick !== 1'b1);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            $display("unexpected timeout: expected end seen hang");
            end_sim;
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, `IDX_PLL_CTL, 0, 8'h13);
        count(64);
        check("default ticks", nt, 8);
        repeat (1300) @(posedge clk_i);
        bus(0, `IDX_PLL_CTL, 0, 8'h53);
        check("lock pin", lock, 1);
        bus(1, `IDX_PLL_CTL, 8'h33);
        bus(0, `IDX_PLL_CTL, 0, 8'h73);
        bus(0, 10'h000, 0, 8'h00);
        sel <= 4'h0;
        bus(1, `IDX_PLL_CTL, 8'h00);
        sel <= 4'hF;
        bus(0, `IDX_PLL_CTL, 0, 8'h73);
        $display("test reset done");
        for (int n = 0; n < 8; n++) begin
            bus(1, `IDX_PLL_CTL, 8'(n));
            bus(0, `IDX_PLL_CTL, 0, 8'h40 | 8'(n));
            repeat (300) @(posedge clk_i);
            count(1024);
            check("core ticks", nt, 1024 >> n);
            check("mod ticks", nm, 2);
            check("mod off core", nbad, 0);
        end
        bus(0, `IDX_IRQ_STS, 0, 8'h02);
        bus(1, `IDX_IRQ_EN, 8'h02);
        check("irq raised", irq, 1);
        bus(1, `IDX_IRQ_EN, 8'h00);
        check("irq masked", irq, 0);
        bus(1, `IDX_IRQ_CLR, 8'h03);
        bus(0, `IDX_IRQ_STS, 0, 8'h00);
        $display("test divider done");
        bus(1, `IDX_PLL_CTL, 8'h0B);
        repeat (300) @(posedge clk_i);
        irq_act <= 1'b1;
        repeat (20) @(posedge clk_i);
        count(64);
        check("fast irq ticks", nt, 64);
        irq_act <= 1'b0;
        repeat (20) @(posedge clk_i);
        count(64);
        check("after irq ticks", nt, 8);
        bus(1, `IDX_PLL_CTL, 8'h83);
        pdn <= 1'b1;
        repeat (3) @(posedge clk_i);
        check("osc halted", osc_halt, 1);
        bus(1, `IDX_PLL_CTL, 8'h03);
        repeat (3) @(posedge clk_i);
        check("osc running", osc_halt, 0);
        pdn <= 1'b0;
        bus(1, `IDX_CHIP_CFG, 8'h10);
        bus(0, `IDX_CHIP_CFG, 0, 8'h10);
        ext_run <= 1'b1;
        repeat (50) @(posedge clk_i);
        count(400);
        check("ext ticks", nt, 20);
        ext_run <= 1'b0;
        bus(1, `IDX_CHIP_CFG, 8'h00);
        bus(1, `IDX_IRQ_CLR, 8'h03);
        $display("test modes done");
        bus(1, `IDX_IRQ_EN, 8'h01);
        fitted <= 1'b0;
        repeat (700) @(posedge clk_i);
        check("core halted", halt, 1);
        check("lock lost", lock, 0);
        check("rail irq", irq, 1);
        count(64);
        check("halted ticks", nt, 0);
        bus(0, `IDX_IRQ_STS, 0, 8'h01);
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (1300) @(posedge clk_i);
        check("no crystal lock", lock, 0);
        count(64);
        check("free run ticks", nt, 8);
        bus(0, `IDX_PLL_CTL, 0, 8'h13);
        $display("test crystal loss done");
        end_sim;
    end
endmodule // test_pll_clock_control
